// ==== lwr_watchdog.sv ====
`timescale 1ns/1ps
`default_nettype none
module lwr_watchdog #(
    parameter int LfoDivCycles = lwr_pkg::LfoDiv
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             wdtResetReq
);
    localparam int CntW = lwr_pkg::BaseBits + 8;

    // ==============================
    // low-frequency tick divider
    logic [15:0]             lfoDiv_q;
    logic                    lfoTick;
    assign lfoTick = (lfoDiv_q == 16'(LfoDivCycles - 1));
    always_ff @(posedge clock) begin
        if (rst || lfoTick) begin
            lfoDiv_q <= 16'h0000;
        end else begin
            lfoDiv_q <= lfoDiv_q + 16'h0001;
        end
    end

    // ==============================
    // axi write side
    logic                    awHeld_q;
    logic                    wHeld_q;
    logic [3:0]              awAddr_q;
    logic [31:0]             wData_q;
    logic [3:0]              wStrb_q;
    logic                    wrFire;
    assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
    assign s_axi_wready  = !wHeld_q && !s_axi_bvalid;
    assign wrFire        = awHeld_q && wHeld_q && !s_axi_bvalid;
    // address and data may arrive in either order
    always_ff @(posedge clock) begin
        if (rst) begin
            awHeld_q     <= 1'b0;
            wHeld_q      <= 1'b0;
            awAddr_q     <= 4'h0;
            wData_q      <= 32'h00000000;
            wStrb_q      <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= lwr_pkg::RespOkay;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_q <= 1'b1;
                awAddr_q <= s_axi_awaddr[3:0];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
            if (wrFire) begin
                awHeld_q     <= 1'b0;
                wHeld_q      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awAddr_q == lwr_pkg::CtrlOffset ||
                                 awAddr_q == lwr_pkg::RestartOffset ||
                                 awAddr_q == lwr_pkg::StatusOffset)
                                ? lwr_pkg::RespOkay : lwr_pkg::RespSlvErr;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    logic                    ctrlWr;
    logic                    restartWr;
    logic                    statWr;
    assign ctrlWr    = wrFire && awAddr_q == lwr_pkg::CtrlOffset && wStrb_q[0];
    assign restartWr = wrFire && awAddr_q == lwr_pkg::RestartOffset && wStrb_q[0]
                       && wData_q[7:0] == lwr_pkg::RestartKey[7:0];
    assign statWr    = wrFire && awAddr_q == lwr_pkg::StatusOffset && wStrb_q[0];

    // ==============================
    // control register
    logic                    enable_q;
    logic                    lock_q;
    logic [2:0]              interval_q;
    // reset state: running at longest interval, unlocked
    always_ff @(posedge clock) begin
        if (rst) begin
            enable_q   <= 1'b1;
            lock_q     <= 1'b0;
            interval_q <= lwr_pkg::IvlReset;
        end else if (ctrlWr && !lock_q) begin
            enable_q   <= wData_q[lwr_pkg::CtrlEnBit];
            lock_q     <= wData_q[lwr_pkg::CtrlLockBit];
            interval_q <= wData_q[lwr_pkg::CtrlIvlLsb +: lwr_pkg::IvlWidth];
        end
    end

    // ==============================
    // timeout counter and reset request
    logic [CntW-1:0]         count_q;
    logic [CntW-1:0]         lastCount;
    logic                    overflow;
    logic                    ovfSeen_q;
    logic [2:0]              rstHold_q;
    // timeout is 2^(BaseBits+interval) low-frequency ticks from a cleared count
    assign lastCount = CntW'((32'h00000001 << (lwr_pkg::BaseBits + int'(interval_q)))
                             - 32'h00000001);
    // compare with >= so a shortened interval expires at once, not after a wrap
    assign overflow = lfoTick && enable_q && (count_q >= lastCount);
    always_ff @(posedge clock) begin
        if (rst || restartWr || overflow || !enable_q) begin
            count_q <= '0;
        end else if (lfoTick) begin
            count_q <= count_q + 1'b1;
        end
    end
    // request stands a few cycles so the system reset catches it
    always_ff @(posedge clock) begin
        if (rst) begin
            rstHold_q <= 3'h0;
        end else if (overflow) begin
            rstHold_q <= 3'(lwr_pkg::SysRstCycles);
        end else if (rstHold_q != 3'h0) begin
            rstHold_q <= rstHold_q - 3'h1;
        end
    end
    // internal request only; no pin driver exists here
    assign wdtResetReq = (rstHold_q != 3'h0);
    // sticky cause flag, survives the reset it caused only outside this block
    always_ff @(posedge clock) begin
        if (rst) begin
            ovfSeen_q <= 1'b0;
        end else if (overflow) begin
            ovfSeen_q <= 1'b1;
        end else if (statWr && wData_q[lwr_pkg::StatOvfBit]) begin
            ovfSeen_q <= 1'b0;
        end
    end

    // ==============================
    // axi read side
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge clock) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= lwr_pkg::RespOkay;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= lwr_pkg::RespOkay;
            case (s_axi_araddr[3:0])
                lwr_pkg::CtrlOffset: begin
                    s_axi_rdata <= {25'h0, interval_q, 2'h0, lock_q, enable_q};
                end
                lwr_pkg::RestartOffset: begin
                    s_axi_rdata <= 32'h00000000;
                end
                lwr_pkg::StatusOffset: begin
                    s_axi_rdata <= {13'h0, count_q, ovfSeen_q};
                end
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= lwr_pkg::RespSlvErr;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ==============================
    // checks
    a_lock_holds_config: assert property (@(posedge clock) disable iff (rst)
        lock_q |=> lock_q && $stable(interval_q) && $stable(enable_q))
        else $error("config changed while locked");
    a_lock_no_disable: assert property (@(posedge clock) disable iff (rst)
        (lock_q && enable_q) |=> enable_q)
        else $error("disabled while locked");
    a_disable_no_reset: assert property (@(posedge clock) disable iff (rst)
        (!enable_q && !wdtResetReq) |=> !wdtResetReq)
        else $error("overflow while disabled");
    a_overflow_reset_req: assert property (@(posedge clock) disable iff (rst)
        overflow |=> wdtResetReq [*4] ##1 !wdtResetReq || overflow)
        else $error("reset request wrong length");
    a_count_lfo_only: assert property (@(posedge clock) disable iff (rst)
        (!lfoTick && !restartWr && enable_q) |=> $stable(count_q))
        else $error("count moved without tick");
    a_restart_clears: assert property (@(posedge clock) disable iff (rst)
        restartWr |=> count_q == '0)
        else $error("restart did not clear count");
    a_reset_defaults: assert property (@(posedge clock)
        $fell(rst) |-> enable_q && interval_q == lwr_pkg::IvlReset && !lock_q)
        else $error("bad state after reset");
    a_req_from_ovf: assert property (@(posedge clock) disable iff (rst)
        $rose(wdtResetReq) |-> $past(overflow))
        else $error("reset request without overflow");
endmodule : lwr_watchdog
`default_nettype wire

// ==== lwr_pkg.sv ====
`default_nettype none
package lwr_pkg;
    // ==============================
    // register map (byte addresses)
    localparam logic [3:0]  CtrlOffset    = 4'h0;
    localparam logic [3:0]  RestartOffset = 4'h4;
    localparam logic [3:0]  StatusOffset  = 4'h8;
    // ==============================
    // control register fields
    localparam int          CtrlEnBit     = 0;
    localparam int          CtrlLockBit   = 1;
    localparam int          CtrlIvlLsb    = 4;
    localparam int          IvlWidth      = 3;
    localparam logic [2:0]  IvlReset      = 3'h7;
    localparam int          StatOvfBit    = 0;
    // restart key written to the restart register
    localparam logic [31:0] RestartKey    = 32'h000000A5;
    // ==============================
    // timing
    localparam int          ClockHz       = 40000000;
    localparam int          LfoHz         = 80000;
    localparam int          LfoDiv        = ClockHz / LfoHz;
    localparam int          BaseBits      = 10;
    localparam int          SysRstCycles  = 4;
    // ==============================
    // axi responses
    localparam logic [1:0]  RespOkay      = 2'h0;
    localparam logic [1:0]  RespSlvErr    = 2'h2;
endpackage : lwr_pkg
`default_nettype wire

// ==== lowfreq_watchdog_reset_timer_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module lowfreq_watchdog_reset_timer_tb;
    // ==============================
    // clock, reset and bus signals
    logic        clock = 1'h0;
    logic        rst = 1'h1;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic        awready, wready, bvalid, arready, rvalid, wdtResetReq;
    logic [1:0]  bresp, rresp;
    int          errors = 0;
    int          comparisons = 0;
    always #12.5 clock = ~clock;
    // short divider keeps a one-interval timeout near 2048 clocks
    lwr_watchdog #(.LfoDivCycles(2)) i_dut (.clock(clock), .rst(rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .wdtResetReq(wdtResetReq));
    // ==============================
    // shared tasks
    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    // readies are sampled mid-cycle, safe since inputs move only after rising edges
    // no local limit: a hung handshake is ended by the bench watchdog
    task wr(input logic [3:0] a, input logic [31:0] d);
        logic aw, w, b;
        @(posedge clock);
        awaddr <= {28'h0000000, a}; wdata <= d; awvalid <= 1'h1; wvalid <= 1'h1; bready <= 1'h1;
        b = 1'h0;
        while (!b) begin
            @(negedge clock); aw = awready; w = wready; b = bvalid;
            @(posedge clock);
            if (aw) awvalid <= 1'h0;
            if (w) wvalid <= 1'h0;
            if (b) bready <= 1'h0;
        end
    endtask : wr
    task rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar, v;
        @(posedge clock);
        araddr <= {28'h0000000, a}; arvalid <= 1'h1; rready <= 1'h1;
        v = 1'h0;
        while (!v) begin
            @(negedge clock); ar = arready; v = rvalid; d = rdata; r = rresp;
            @(posedge clock);
            if (ar) arvalid <= 1'h0;
            if (v) rready <= 1'h0;
        end
    endtask : rd
    task do_reset;
        @(posedge clock); rst <= 1'h1;
        repeat (12) @(posedge clock);
        rst <= 1'h0;
    endtask : do_reset
    // bounded wait for the internal reset request
    task wait_req(output int n);
        n = 0;
        while (wdtResetReq !== 1'h1 && n < 3000) begin
            @(negedge clock); n++;
        end
    endtask : wait_req
    task report_and_stop;
        $display("counts: %0d comparisons, %0d errors", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    // ==============================
    // scenarios
    task t_reset;
        logic [31:0] d;
        logic [1:0]  r;
        rd(lwr_pkg::CtrlOffset, d, r);
        check(d, 32'h00000071);
        check({30'h0, r}, {30'h0, lwr_pkg::RespOkay});
        rd(4'hC, d, r);
        check({30'h0, r}, {30'h0, lwr_pkg::RespSlvErr});
        $display("t_reset done");
    endtask : t_reset
    task t_restart;
        logic [31:0] d;
        logic [1:0]  r;
        int          n;
        wr(lwr_pkg::CtrlOffset, 32'h00000001);
        wr(lwr_pkg::RestartOffset, lwr_pkg::RestartKey);
        repeat (1500) @(posedge clock);
        wr(lwr_pkg::RestartOffset, lwr_pkg::RestartKey);
        rd(lwr_pkg::StatusOffset, d, r);
        check({31'h0, d[18:1] < 18'h8}, 32'h1);
        wait_req(n);
        check({31'h0, n >= 2020 && n <= 2060}, 32'h1);
        repeat (3) @(negedge clock);
        check({31'h0, wdtResetReq}, 32'h1);
        rd(lwr_pkg::StatusOffset, d, r);
        check({31'h0, d[0]}, 32'h1);
        wr(lwr_pkg::StatusOffset, 32'h00000001);
        rd(lwr_pkg::StatusOffset, d, r);
        check({31'h0, d[0]}, 32'h0);
        do_reset();
        $display("t_restart done");
    endtask : t_restart
    task t_disable;
        logic [31:0] d;
        logic [1:0]  r;
        int          n;
        wr(lwr_pkg::CtrlOffset, 32'h00000000);
        rd(lwr_pkg::CtrlOffset, d, r);
        check(d, 32'h00000000);
        wait_req(n);
        check(n, 32'd3000);
        $display("t_disable done");
    endtask : t_disable
    task t_lock;
        logic [31:0] d;
        logic [1:0]  r;
        int          n;
        wr(lwr_pkg::CtrlOffset, 32'h00000003);
        wr(lwr_pkg::RestartOffset, lwr_pkg::RestartKey);
        wr(lwr_pkg::CtrlOffset, 32'h00000070);
        rd(lwr_pkg::CtrlOffset, d, r);
        check(d, 32'h00000003);
        wait_req(n);
        check({31'h0, n >= 2000 && n <= 2060}, 32'h1);
        do_reset();
        rd(lwr_pkg::CtrlOffset, d, r);
        check(d, 32'h00000071);
        $display("t_lock done");
    endtask : t_lock
    // ==============================
    // main sequence and watchdog
    initial begin
        repeat (12) @(posedge clock);
        rst <= 1'h0;
        t_reset();
        t_restart();
        t_disable();
        t_lock();
        report_and_stop();
    end
    // whole run needs about 9k clocks, allow 40k
    initial begin
        #1000000;
        errors++;
        report_and_stop();
    end
endmodule : lowfreq_watchdog_reset_timer_tb
`default_nettype wire
